// ---- cgen_ctrl.sv ----
// How it works
// - Slow clock RC by default, crystal by software.
// - Reset: fast RC on at 4 MHz, selected.
// - Frequency change restarts fast RC, gates main clock while fast RC is its source.
// - Fast RC disable clears its stable flag.
// - Reset: crystal off and not selected.
// - Crystal disable clears its stable flag.
// - Crystal enable loads count, counts slow/8.
// - Count zero sets crystal stable, may interrupt.
// - Glitch-free source switch with done flag.
// - Wait mode forces fast RC as source.
// - Frequency meter restarts on stability or switch.
// - Stops at 16th slow fall, sets ready.
// - Divider zero holds PLL output low.
// - Multiplier zero powers PLL down.
// - PLL change reloads lock count per slow tick.
// - USB PLL enable loads count, counts slow/8.
// - Each status register flag can raise the interrupt; the meter ready flag cannot.
`include "cgen_regs.svh"
module cgen_ctrl (
   input  wire logic                       clock,              // System clock, 125 MHz.
   input  wire logic                       arst_n,             // Asynchronous reset, active low.
   input  wire logic [7:0]                 addr,               // Register byte address.
   input  wire logic [31:0]                wr_data,            // Register write data.
   input  wire logic                       wr_en,              // Write strobe.
   input  wire logic                       rd_en,              // Read strobe.
   output      logic [31:0]                rd_data,            // Read data, cycle after rd_en.
   input  wire logic                       slow_clock,         // Slow clock, sampled.
   input  wire logic                       main_clock,         // Main clock, sampled for measuring.
   input  wire logic                       wait_mode,          // System in wait mode.
   output      logic                       slow_xtal_select,   // Slow clock from crystal.
   output      logic                       slow_osc_bypass,    // Slow oscillator bypass.
   output      logic                       fast_rc_enable,     // Fast RC oscillator power.
   output      logic [1:0]                 fast_rc_freq_sel,   // Fast RC frequency code.
   output      logic                       xtal_osc_enable,    // Crystal oscillator power.
   output      logic                       main_src_mux,       // Main mux: 1 crystal, 0 fast RC.
   output      logic                       main_clock_run,     // Main clock gate open.
   output      cgen_pkg::cgen_pll_cfg_type pll_a_cfg,          // PLL A settings.
   output      logic                       pll_a_power,        // PLL A powered.
   output      logic                       pll_a_out_en,       // PLL A output not held low.
   output      logic                       usb_pll_enable,     // USB PLL power.
   output      logic                       irq                 // Interrupt request, level.
);
   logic sl_s1, sl_s2, sl_s3, mc_s1, mc_s2, mc_s3, wt_s1, wt_s2;
   logic slow_xtal_r, slow_byp_r, frc_en_r, xt_en_r, src_sel_r, usb_en_r;
   logic [1:0] frc_sel_r;
   logic [3:0] usb_cnt_r;
   logic [4:0] int_mask_r;
   cgen_pkg::cgen_pll_cfg_type pll_r;
   logic pll_pow_r, pll_oe_r;
   logic frc_stable_r, xt_stable_r, pll_locked_r, usb_locked_r;
   logic frc_run_r, xt_run_r, pll_run_r, usb_run_r;
   logic [2:0] frc_tmr_r, div8_r;
   logic [7:0] xt_tmr_r;
   logic [5:0] pll_tmr_r;
   logic [3:0] usb_tmr_r;
   cgen_pkg::cgen_sw_type sw_r;
   logic [1:0] sw_tmr_r;
   logic cur_src_r, sw_done_r, eff_src_q_r, frc_stable_q_r, xt_stable_q_r;
   cgen_pkg::cgen_fm_type fm_r;
   logic [4:0] fm_edges_r;
   logic [15:0] fm_value_r;
   logic fm_ready_r;
   logic [31:0] rd_data_r;
   logic irq_r;

   // The mains and the slow clock are sampled, so their edges cost two cycles of latency.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         {sl_s1, sl_s2, sl_s3} <= 3'h0;
         {mc_s1, mc_s2, mc_s3} <= 3'h0;
         {wt_s1, wt_s2} <= 2'h0;
      end else begin
         {sl_s1, sl_s2, sl_s3} <= {slow_clock, sl_s1, sl_s2};
         {mc_s1, mc_s2, mc_s3} <= {main_clock, mc_s1, mc_s2};
         {wt_s1, wt_s2} <= {wait_mode, wt_s1};
      end
   end

   wire slow_rise = sl_s2 & ~sl_s3;
   wire slow_fall = ~sl_s2 & sl_s3;
   wire main_rise = mc_s2 & ~mc_s3;
   wire div8_tick = slow_rise & (div8_r == 3'h7);

   wire wr_slow = wr_en & (addr == `CGEN_OFF_SLOW);
   wire wr_main = wr_en & (addr == `CGEN_OFF_MAIN);
   wire wr_plla = wr_en & (addr == `CGEN_OFF_PLLA);
   wire wr_uckr = wr_en & (addr == `CGEN_OFF_UCKR);
   wire wr_ier  = wr_en & (addr == `CGEN_OFF_IER);
   wire wr_idr  = wr_en & (addr == `CGEN_OFF_IDR);

   wire       w_rcen = wr_data[`CGEN_MAIN_RCEN];
   wire       w_xten = wr_data[`CGEN_MAIN_XTEN];
   wire [1:0] w_rcf_raw = wr_data[`CGEN_MAIN_RCF_HI:`CGEN_MAIN_RCF_LO];
   // Code 3 is not a frequency; it keeps the present setting.
   wire [1:0] w_rcf = (w_rcf_raw == 2'h3) ? frc_sel_r : w_rcf_raw;
   wire [7:0] w_xcnt = wr_data[`CGEN_MAIN_CNT_HI:`CGEN_MAIN_CNT_LO];
   wire       w_uen = wr_data[`CGEN_UCKR_EN];
   wire [3:0] w_ucnt = wr_data[`CGEN_UCKR_CNT_HI:`CGEN_UCKR_CNT_LO];
   // Bits 15:14 of the PLL word are a gap, so the fields are gathered one by one.
   wire cgen_pkg::cgen_pll_cfg_type w_pll = {wr_data[26:16], wr_data[13:8], wr_data[7:0]};
   wire       w_pll_pow = (w_pll.mul != 11'h000);
   wire       w_pll_oe  = w_pll_pow & (w_pll.div != 8'h00);

   wire frc_off   = wr_main & ~w_rcen;
   wire frc_start = wr_main & w_rcen & (~frc_en_r | (w_rcf != frc_sel_r));
   wire xt_off    = wr_main & ~w_xten;
   wire xt_start  = wr_main & w_xten & ~xt_en_r;
   wire pll_off   = wr_plla & (w_pll.mul == 11'h000);
   wire pll_start = wr_plla & ~pll_off & (w_pll != pll_r);
   wire usb_off   = wr_uckr & ~w_uen;
   wire usb_start = wr_uckr & w_uen & ~usb_en_r;

   wire eff_src = src_sel_r & ~wt_s2;

   // Software settings.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         slow_xtal_r <= 1'b0;
         slow_byp_r  <= 1'b0;
         frc_en_r    <= 1'b1;
         frc_sel_r   <= `CGEN_RCF_4MHZ;
         xt_en_r     <= 1'b0;
         src_sel_r   <= 1'b0;
         pll_r       <= '0;
         pll_pow_r   <= 1'b0;
         pll_oe_r    <= 1'b0;
         usb_en_r    <= 1'b0;
         usb_cnt_r   <= 4'h0;
         int_mask_r  <= 5'h00;
      end else begin
         // The crystal choice cannot be undone short of reset.
         if (wr_slow) begin
            slow_xtal_r <= slow_xtal_r | wr_data[`CGEN_SLOW_XTAL];
            slow_byp_r  <= wr_data[`CGEN_SLOW_BYP];
         end
         if (wr_main) begin
            frc_en_r  <= w_rcen;
            frc_sel_r <= w_rcf;
            xt_en_r   <= w_xten;
            src_sel_r <= wr_data[`CGEN_MAIN_SEL];
         end
         if (wr_plla) begin
            pll_r     <= w_pll;
            pll_pow_r <= w_pll_pow;
            pll_oe_r  <= w_pll_oe;
         end
         if (wr_uckr) begin
            usb_en_r  <= w_uen;
            usb_cnt_r <= w_ucnt;
         end
         if (wr_ier) begin
            int_mask_r <= int_mask_r | wr_data[4:0];
         end else if (wr_idr) begin
            int_mask_r <= int_mask_r & ~wr_data[4:0];
         end
      end
   end

   // Slow clock divided by 8 for the crystal and USB PLL counters.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         div8_r <= 3'h0;
      end else if (slow_rise) begin
         div8_r <= div8_r + 3'h1;
      end
   end

   // Fast RC settling; it starts out settled so the system can boot from it.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         frc_stable_r <= 1'b1;
         frc_run_r    <= 1'b0;
         frc_tmr_r    <= 3'h0;
      end else if (frc_off) begin
         frc_stable_r <= 1'b0;
         frc_run_r    <= 1'b0;
      end else if (frc_start) begin
         frc_stable_r <= 1'b0;
         frc_run_r    <= 1'b1;
         frc_tmr_r    <= `CGEN_FRC_SETTLE;
      end else if (frc_run_r && slow_rise) begin
         if (frc_tmr_r <= 3'h1) begin
            frc_stable_r <= 1'b1;
            frc_run_r    <= 1'b0;
            frc_tmr_r    <= 3'h0;
         end else begin
            frc_tmr_r <= frc_tmr_r - 3'h1;
         end
      end
   end

   // Crystal startup countdown.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         xt_stable_r <= 1'b0;
         xt_run_r    <= 1'b0;
         xt_tmr_r    <= 8'h00;
      end else if (xt_off) begin
         xt_stable_r <= 1'b0;
         xt_run_r    <= 1'b0;
      end else if (xt_start) begin
         xt_stable_r <= 1'b0;
         xt_run_r    <= 1'b1;
         xt_tmr_r    <= w_xcnt;
      end else if (xt_run_r && div8_tick) begin
         if (xt_tmr_r <= 8'h01) begin
            xt_stable_r <= 1'b1;
            xt_run_r    <= 1'b0;
            xt_tmr_r    <= 8'h00;
         end else begin
            xt_tmr_r <= xt_tmr_r - 8'h01;
         end
      end
   end

   // PLL A lock countdown, one step per slow clock period.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pll_locked_r <= 1'b0;
         pll_run_r    <= 1'b0;
         pll_tmr_r    <= 6'h00;
      end else if (pll_off) begin
         pll_locked_r <= 1'b0;
         pll_run_r    <= 1'b0;
      end else if (pll_start) begin
         pll_locked_r <= 1'b0;
         pll_run_r    <= 1'b1;
         pll_tmr_r    <= w_pll.cnt;
      end else if (pll_run_r && slow_rise) begin
         if (pll_tmr_r <= 6'h01) begin
            pll_locked_r <= 1'b1;
            pll_run_r    <= 1'b0;
            pll_tmr_r    <= 6'h00;
         end else begin
            pll_tmr_r <= pll_tmr_r - 6'h01;
         end
      end
   end

   // USB PLL lock countdown on the slow clock divided by 8.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         usb_locked_r <= 1'b0;
         usb_run_r    <= 1'b0;
         usb_tmr_r    <= 4'h0;
      end else if (usb_off) begin
         usb_locked_r <= 1'b0;
         usb_run_r    <= 1'b0;
      end else if (usb_start) begin
         usb_locked_r <= 1'b0;
         usb_run_r    <= 1'b1;
         usb_tmr_r    <= w_ucnt;
      end else if (usb_run_r && div8_tick) begin
         if (usb_tmr_r <= 4'h1) begin
            usb_locked_r <= 1'b1;
            usb_run_r    <= 1'b0;
            usb_tmr_r    <= 4'h0;
         end else begin
            usb_tmr_r <= usb_tmr_r - 4'h1;
         end
      end
   end

   // Source switch: gate off, change the mux while stopped, then reopen.
   // Holding the gate shut across slow clock edges is what makes it glitch free.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sw_r      <= cgen_pkg::CGEN_SW_IDLE;
         sw_tmr_r  <= 2'h0;
         cur_src_r <= 1'b0;
         sw_done_r <= 1'b1;
      end else begin
         unique case (sw_r)
            cgen_pkg::CGEN_SW_IDLE: begin
               if (eff_src != cur_src_r) begin
                  sw_r      <= cgen_pkg::CGEN_SW_STOP;
                  sw_tmr_r  <= `CGEN_SW_GAP;
                  sw_done_r <= 1'b0;
               end
            end
            cgen_pkg::CGEN_SW_STOP: begin
               if (slow_rise) begin
                  if (sw_tmr_r <= 2'h1) begin
                     cur_src_r <= eff_src;
                     sw_r      <= cgen_pkg::CGEN_SW_MUX;
                  end else begin
                     sw_tmr_r <= sw_tmr_r - 2'h1;
                  end
               end
            end
            cgen_pkg::CGEN_SW_MUX: begin
               if (slow_rise) begin
                  sw_r      <= cgen_pkg::CGEN_SW_IDLE;
                  sw_done_r <= 1'b1;
               end
            end
            default: begin
               sw_r <= cgen_pkg::CGEN_SW_IDLE;
            end
         endcase
      end
   end

   wire src_ok   = cur_src_r ? xt_stable_r : frc_stable_r;
   wire run_nxt  = (sw_r == cgen_pkg::CGEN_SW_IDLE) & src_ok;
   wire fm_trig  = (frc_stable_r & ~frc_stable_q_r & ~cur_src_r)
                 | (xt_stable_r & ~xt_stable_q_r & cur_src_r)
                 | (eff_src != eff_src_q_r);

   // Frequency meter: main clock edges from a slow clock rise to the 16th slow clock fall.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         fm_r           <= cgen_pkg::CGEN_FM_IDLE;
         fm_edges_r     <= 5'h00;
         fm_value_r     <= 16'h0000;
         fm_ready_r     <= 1'b0;
         eff_src_q_r    <= 1'b0;
         // The fast RC boots settled, so its history starts high and reset raises no false trigger.
         frc_stable_q_r <= 1'b1;
         xt_stable_q_r  <= 1'b0;
      end else begin
         eff_src_q_r    <= eff_src;
         frc_stable_q_r <= frc_stable_r;
         xt_stable_q_r  <= xt_stable_r;
         if (fm_trig) begin
            fm_r       <= cgen_pkg::CGEN_FM_ARM;
            fm_ready_r <= 1'b0;
         end else begin
            unique case (fm_r)
               cgen_pkg::CGEN_FM_IDLE: begin
               end
               cgen_pkg::CGEN_FM_ARM: begin
                  if (slow_rise) begin
                     fm_r       <= cgen_pkg::CGEN_FM_COUNT;
                     fm_value_r <= 16'h0000;
                     fm_edges_r <= 5'h00;
                  end
               end
               cgen_pkg::CGEN_FM_COUNT: begin
                  if (main_rise) begin
                     fm_value_r <= fm_value_r + 16'h0001;
                  end
                  if (slow_fall) begin
                     fm_edges_r <= fm_edges_r + 5'h01;
                     if (fm_edges_r == `CGEN_FM_LAST) begin
                        fm_r       <= cgen_pkg::CGEN_FM_IDLE;
                        fm_ready_r <= 1'b1;
                     end
                  end
               end
               default: begin
                  fm_r <= cgen_pkg::CGEN_FM_IDLE;
               end
            endcase
         end
      end
   end

   // Flags come straight from their registers, so software always reads settled levels.
   wire [4:0] status = {frc_stable_r, sw_done_r, usb_locked_r, pll_locked_r, xt_stable_r};

   wire [31:0] rd_mux =
      (addr == `CGEN_OFF_SLOW) ? {30'h0, slow_byp_r, slow_xtal_r} :
      (addr == `CGEN_OFF_MAIN) ? {16'h0, xt_tmr_r, src_sel_r, 1'b0, frc_sel_r, 2'h0, frc_en_r, xt_en_r} :
      (addr == `CGEN_OFF_MCFR) ? {15'h0, fm_ready_r, fm_value_r} :
      (addr == `CGEN_OFF_PLLA) ? {5'h0, pll_r.mul, 2'h0, pll_r.cnt, pll_r.div} :
      (addr == `CGEN_OFF_UCKR) ? {8'h0, usb_cnt_r, 3'h0, usb_en_r, 16'h0} :
      (addr == `CGEN_OFF_SR)   ? {27'h0, status} :
      (addr == `CGEN_OFF_IMR)  ? {27'h0, int_mask_r} : 32'h0;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rd_data_r <= 32'h0;
         irq_r     <= 1'b0;
      end else begin
         rd_data_r <= rd_en ? rd_mux : 32'h0;
         irq_r     <= |(status & int_mask_r);
      end
   end

   logic run_r;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         run_r <= 1'b1;
      end else begin
         run_r <= run_nxt;
      end
   end

   assign rd_data          = rd_data_r;
   assign irq              = irq_r;
   assign slow_xtal_select = slow_xtal_r;
   assign slow_osc_bypass  = slow_byp_r;
   assign fast_rc_enable   = frc_en_r;
   assign fast_rc_freq_sel = frc_sel_r;
   assign xtal_osc_enable  = xt_en_r;
   assign main_src_mux     = cur_src_r;
   assign main_clock_run   = run_r;
   assign pll_a_cfg        = pll_r;
   assign pll_a_power      = pll_pow_r;
   assign pll_a_out_en     = pll_oe_r;
   assign usb_pll_enable   = usb_en_r;
endmodule

// ---- cgen_ctrl_props.sv ----
`include "cgen_regs.svh"
module cgen_ctrl_props (
   input wire logic                       clock,            // Clock.
   input wire logic                       arst_n,           // Reset.
   input wire logic [7:0]                 addr,             // Address.
   input wire logic [31:0]                wr_data,          // Write data.
   input wire logic                       wr_en,            // Write strobe.
   input wire logic                       rd_en,            // Read strobe.
   input wire logic [31:0]                rd_data,          // Read data.
   input wire logic                       slow_clock,       // Slow clock.
   input wire logic                       main_clock,       // Main clock.
   input wire logic                       wait_mode,        // Wait mode.
   input wire logic                       slow_xtal_select, // Slow source.
   input wire logic                       slow_osc_bypass,  // Bypass.
   input wire logic                       fast_rc_enable,   // RC power.
   input wire logic [1:0]                 fast_rc_freq_sel, // RC code.
   input wire logic                       xtal_osc_enable,  // Crystal power.
   input wire logic                       main_src_mux,     // Main mux.
   input wire logic                       main_clock_run,   // Main gate.
   input wire cgen_pkg::cgen_pll_cfg_type pll_a_cfg,        // PLL settings.
   input wire logic                       pll_a_power,      // PLL power.
   input wire logic                       pll_a_out_en,     // PLL output.
   input wire logic                       usb_pll_enable,   // USB PLL power.
   input wire logic                       irq               // Interrupt.
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   wire main_wr = wr_en && addr == `CGEN_OFF_MAIN;
   // The gate must shut promptly so no shortened main clock pulse escapes.
   sequence gate_shut;
      ##[1:6] !main_clock_run;
   endsequence
   sequence gate_back;
      ##[1:300] main_clock_run;
   endsequence
   reset_state_a: assert property (
      $rose(arst_n) |-> fast_rc_enable && fast_rc_freq_sel == 2'h0 && !xtal_osc_enable && !main_src_mux)
      else $error("state after reset wrong");
   div_zero_a: assert property (
      pll_a_cfg.div == 8'h00 |-> !pll_a_out_en) else $error("pll output not held low");
   mul_zero_a: assert property (
      pll_a_power == (pll_a_cfg.mul != 11'h000)) else $error("pll power mismatch");
   rc_retune_a: assert property (
      main_wr && wr_data[1] && fast_rc_enable && wr_data[5:4] != 2'h3 && wr_data[5:4] != fast_rc_freq_sel
      && !wr_data[7] && !main_src_mux && !wait_mode |-> gate_shut ##0 gate_back) else $error("retune gating wrong");
   rc_off_a: assert property (
      main_wr && !wr_data[1] && !main_src_mux |-> gate_shut) else $error("gate open with rc off");
   xtal_off_a: assert property (
      main_wr && !wr_data[0] && main_src_mux |-> gate_shut) else $error("gate open with crystal off");
   wait_force_a: assert property (
      $rose(wait_mode) |-> ##[1:200] !main_src_mux) else $error("wait mode kept crystal");
   glitch_free_a: assert property (
      $changed(main_src_mux) |-> !main_clock_run && !$past(main_clock_run)) else $error("mux moved with gate open");
   xtal_sticky_a: assert property (
      slow_xtal_select |=> slow_xtal_select) else $error("slow crystal select dropped");
   xtal_hold_a: assert property (
      !slow_xtal_select && !(wr_en && addr == `CGEN_OFF_SLOW && wr_data[0]) |=> !slow_xtal_select)
      else $error("slow crystal select without write");
   rd_idle_a: assert property (
      !rd_en |=> rd_data == 32'h0) else $error("read data outside slot");
endmodule
bind cgen_ctrl cgen_ctrl_props u_props (.clock, .arst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .slow_clock,
   .main_clock, .wait_mode, .slow_xtal_select, .slow_osc_bypass, .fast_rc_enable, .fast_rc_freq_sel,
   .xtal_osc_enable, .main_src_mux, .main_clock_run, .pll_a_cfg, .pll_a_power, .pll_a_out_en, .usb_pll_enable, .irq);

// ---- cgen_ctrl_tb.sv ----
`include "cgen_regs.svh"
module cgen_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                       clock      = 1'b0;
   logic                       arst_n     = 1'b0;
   logic                       slow_clock = 1'b0;
   logic                       main_clock = 1'b0;
   logic                       wait_mode  = 1'b0;
   logic                       wr_en      = 1'b0;
   logic                       rd_en      = 1'b0;
   logic                       note_r     = 1'b0;
   logic                       pend       = 1'b0;
   logic [7:0]                 addr       = 8'h00;
   logic [31:0]                wr_data    = 32'h0;
   logic [31:0]                rd_data, d;
   logic [63:0]                nt;
   logic [63:0]                notes[$];
   logic [1:0]                 fast_rc_freq_sel;
   logic [10:0]                mul;
   logic [7:0]                 div;
   logic                       slow_xtal_select, slow_osc_bypass, fast_rc_enable, xtal_osc_enable;
   logic                       main_src_mux, main_clock_run, pll_a_power, pll_a_out_en, usb_pll_enable, irq;
   cgen_pkg::cgen_pll_cfg_type pll_a_cfg;
   int                         n_errors   = 0;
   int                         compares   = 0;
   cgen_ctrl dut (.clock, .arst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .slow_clock, .main_clock,
      .wait_mode, .slow_xtal_select, .slow_osc_bypass, .fast_rc_enable, .fast_rc_freq_sel, .xtal_osc_enable,
      .main_src_mux, .main_clock_run, .pll_a_cfg, .pll_a_power, .pll_a_out_en, .usb_pll_enable, .irq);
   initial forever #4 clock = ~clock;
   initial forever #64 slow_clock = ~slow_clock;
   // Offset so that no main clock edge lands on a system clock edge.
   initial begin
      #2;
      forever #20 main_clock = ~main_clock;
   end
   task automatic summarize();
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic gap(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      addr    <= a;
      wr_data <= v;
      wr_en   <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask
   // Only noted reads are judged by the monitor; polling reads pass through unjudged.
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic k);
      @(posedge clock);
      addr   <= a;
      rd_en  <= 1'b1;
      note_r <= k;
      if (k) notes.push_back({e, m});
      @(posedge clock);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask
   task automatic poll(input logic [7:0] a, input int b, input logic v);
      for (int i = 0; i < 500; i++) begin
         rd(a, 32'h0, 32'h0, 1'b0);
         if (d[b] === v) return;
      end
      n_errors++;
      $display("[ERR] status bit %0d expected %b seen timeout", b, v);
      summarize();
   endtask
   task automatic set_wait(input logic w);
      @(posedge clock);
      wait_mode <= w;
      for (int i = 0; i < 300; i++) begin
         gap(1);
         if (main_src_mux === !w) return;
      end
      n_errors++;
      $display("[ERR] main_src_mux expected %b seen timeout", !w);
      summarize();
   endtask
   always @(posedge clock) begin
      if (pend) begin
         nt = notes.pop_front();
         chk("rd_data", nt[63:32] & nt[31:0], rd_data & nt[31:0]);
      end
      pend <= rd_en && note_r;
   end
   initial begin
      void'($urandom(16));
      mul = 11'($urandom_range(2047, 1));
      div = 8'($urandom_range(255, 1));
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      gap(1);
      chk("fast_rc_enable", 32'h1, 32'(fast_rc_enable));
      chk("fast_rc_freq_sel", 32'h0, 32'(fast_rc_freq_sel));
      chk("xtal_osc_enable", 32'h0, 32'(xtal_osc_enable));
      chk("main_src_mux", 32'h0, 32'(main_src_mux));
      chk("pll_a_out_en", 32'h0, 32'(pll_a_out_en));
      rd(`CGEN_OFF_SR, 32'h18, 32'h1f, 1'b1);
      wr(8'h24, 32'hffff_ffff);
      rd(8'h24, 32'h0, 32'hffff_ffff, 1'b1);
      wr(`CGEN_OFF_IER, 32'h2);
      wr(`CGEN_OFF_PLLA, {5'h0, mul, 2'h0, 6'h03, 8'h00});
      gap(2);
      chk("pll_a_power", 32'h1, 32'(pll_a_power));
      chk("pll_a_out_en", 32'h0, 32'(pll_a_out_en));
      poll(`CGEN_OFF_SR, 1, 1'b1);
      wr(`CGEN_OFF_PLLA, {5'h0, mul, 2'h0, 6'h03, div});
      gap(2);
      chk("irq", 32'h0, 32'(irq));
      chk("pll_a_cfg", {7'h0, mul, 6'h03, div}, 32'(pll_a_cfg));
      rd(`CGEN_OFF_PLLA, {5'h0, mul, 2'h0, 6'h03, div}, 32'hffff_ffff, 1'b1);
      rd(`CGEN_OFF_SR, 32'h0, 32'h2, 1'b1);
      poll(`CGEN_OFF_SR, 1, 1'b1);
      gap(2);
      chk("irq", 32'h1, 32'(irq));
      chk("pll_a_out_en", 32'h1, 32'(pll_a_out_en));
      wr(`CGEN_OFF_IDR, 32'h2);
      gap(2);
      chk("irq", 32'h0, 32'(irq));
      rd(`CGEN_OFF_IMR, 32'h0, 32'h1f, 1'b1);
      wr(`CGEN_OFF_PLLA, {5'h0, 11'h000, 2'h0, 6'h03, div});
      gap(1);
      chk("pll_a_power", 32'h0, 32'(pll_a_power));
      rd(`CGEN_OFF_SR, 32'h0, 32'h2, 1'b1);
      wr(`CGEN_OFF_MAIN, 32'h22);
      gap(2);
      rd(`CGEN_OFF_SR, 32'h0, 32'h10, 1'b1);
      chk("main_clock_run", 32'h0, 32'(main_clock_run));
      poll(`CGEN_OFF_SR, 4, 1'b1);
      gap(2);
      chk("main_clock_run", 32'h1, 32'(main_clock_run));
      chk("fast_rc_freq_sel", 32'h2, 32'(fast_rc_freq_sel));
      wr(`CGEN_OFF_MAIN, 32'h223);
      gap(2);
      rd(`CGEN_OFF_SR, 32'h0, 32'h1, 1'b1);
      chk("xtal_osc_enable", 32'h1, 32'(xtal_osc_enable));
      poll(`CGEN_OFF_SR, 0, 1'b1);
      wr(`CGEN_OFF_MAIN, 32'h2a3);
      gap(2);
      rd(`CGEN_OFF_SR, 32'h0, 32'h8, 1'b1);
      poll(`CGEN_OFF_SR, 3, 1'b1);
      chk("main_src_mux", 32'h1, 32'(main_src_mux));
      poll(`CGEN_OFF_MCFR, 16, 1'b1);
      chk("freq_meas_value", 32'h1, 32'(d[15:0] >= 16'h31 && d[15:0] <= 16'h33));
      set_wait(1'b1);
      set_wait(1'b0);
      poll(`CGEN_OFF_SR, 3, 1'b1);
      wr(`CGEN_OFF_MAIN, 32'h22);
      gap(2);
      rd(`CGEN_OFF_SR, 32'h0, 32'h1, 1'b1);
      chk("xtal_osc_enable", 32'h0, 32'(xtal_osc_enable));
      poll(`CGEN_OFF_SR, 3, 1'b1);
      wr(`CGEN_OFF_MAIN, 32'h20);
      gap(2);
      rd(`CGEN_OFF_SR, 32'h0, 32'h10, 1'b1);
      chk("main_clock_run", 32'h0, 32'(main_clock_run));
      wr(`CGEN_OFF_MAIN, 32'h22);
      poll(`CGEN_OFF_SR, 4, 1'b1);
      wr(`CGEN_OFF_UCKR, 32'h0021_0000);
      gap(2);
      rd(`CGEN_OFF_SR, 32'h0, 32'h4, 1'b1);
      chk("usb_pll_enable", 32'h1, 32'(usb_pll_enable));
      poll(`CGEN_OFF_SR, 2, 1'b1);
      wr(`CGEN_OFF_SLOW, 32'h3);
      gap(1);
      chk("slow_osc_bypass", 32'h1, 32'(slow_osc_bypass));
      wr(`CGEN_OFF_SLOW, 32'h0);
      gap(1);
      chk("slow_xtal_select", 32'h1, 32'(slow_xtal_select));
      gap(2);
      summarize();
   end
endmodule

// ---- cgen_pkg.sv ----
package cgen_pkg;
   typedef struct packed {
      logic [10:0] mul;
      logic [5:0]  cnt;
      logic [7:0]  div;
   } cgen_pll_cfg_type;
   typedef enum logic [1:0] {
      CGEN_SW_IDLE = 2'b00,
      CGEN_SW_STOP = 2'b01,
      CGEN_SW_MUX  = 2'b10
   } cgen_sw_type;
   typedef enum logic [1:0] {
      CGEN_FM_IDLE  = 2'b00,
      CGEN_FM_ARM   = 2'b01,
      CGEN_FM_COUNT = 2'b10
   } cgen_fm_type;
endpackage

// ---- cgen_regs.svh ----
`ifndef CGEN_REGS_SVH
`define CGEN_REGS_SVH
`define CGEN_OFF_SLOW     8'h00
`define CGEN_OFF_MAIN     8'h04
`define CGEN_OFF_MCFR     8'h08
`define CGEN_OFF_PLLA     8'h0c
`define CGEN_OFF_UCKR     8'h10
`define CGEN_OFF_SR       8'h14
`define CGEN_OFF_IER      8'h18
`define CGEN_OFF_IDR      8'h1c
`define CGEN_OFF_IMR      8'h20
`define CGEN_SLOW_XTAL    0
`define CGEN_SLOW_BYP     1
`define CGEN_MAIN_XTEN    0
`define CGEN_MAIN_RCEN    1
`define CGEN_MAIN_RCF_LO  4
`define CGEN_MAIN_RCF_HI  5
`define CGEN_MAIN_SEL     7
`define CGEN_MAIN_CNT_LO  8
`define CGEN_MAIN_CNT_HI  15
`define CGEN_MCFR_RDY     16
`define CGEN_UCKR_EN      16
`define CGEN_UCKR_CNT_LO  20
`define CGEN_UCKR_CNT_HI  23
`define CGEN_RCF_4MHZ     2'h0
`define CGEN_RCF_12MHZ    2'h2
`define CGEN_FRC_SETTLE   3'h4
`define CGEN_SW_GAP       2'h2
`define CGEN_FM_LAST      5'h0f
`endif
